// >>> rtl/uart_frame_addr_top.sv
// Purpose: Two serial ports with stop-bit framing check and address match.
// Assumes: Byte register port with one-cycle read latency; pins asynchronous.
// Notes:   Interrupt output is a level built from the sticky status bits.
//
// Local design decisions: strobed register access and the address map.
`default_nettype none
`include "uart_addr_regs.svh"

// What this block does
// - Stop-bit checks in modes 1, 2, 3 only when framing check enabled.
// - With checks on, an invalid stop bit sets the frame error flag.
// - Frame error stays until software clear or reset; good frames keep it.
// - With checks on, receive complete rises at stop bit, not last data bit.
// - Address recognition is active when multiprocessor enable is set, except in mode 0.
// - With recognition on, receive complete only for matching address frames.
// - Mode 1 recognition uses stop as ninth bit; needs match and valid stop.
// - Multiprocessor enable has no effect in mode 0.
// - Given address is own address with mask zeros as don't-care bits.
// - Broadcast address is own OR mask; its zero bits are don't-care.
// - Address accepted if it matches given or broadcast address.
// - Reset clears own address and mask, so every address matches.
// - Transmit and receive run at once, at independent baud rates.
// - Both ports have identical, independent framing and address logic.
module uart_frame_addr_top
   import uart_addr_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [7:0] o_rd_data,
   // Serial lines, bit index is the port
   input wire logic [1:0] i_rx_pin,
   output logic [1:0] o_tx_pin,
   // Interrupt
   output logic o_irq
);

   localparam int NP = `NUM_PORTS;

   logic [7:0] scr_q [NP];
   logic [NP-1:0] fe_q;
   logic [7:0] own_addr_q [NP];
   logic [7:0] mask_q [NP];
   logic [7:0] rx_buf_q [NP];
   logic [7:0] rx_div_q [NP];
   logic [7:0] tx_div_q [NP];
   logic [NP-1:0] fce_q;
   logic [5:0] irq_stat_q;
   logic [5:0] irq_mask_q;
   logic [5:0] irq_set;
   logic [7:0] rd_data_q;
   logic [7:0] rd_mux;
   logic pwr_wr;
   logic irq_stat_wr;
   logic irq_mask_wr;
   logic [NP-1:0] scr_wr;
   logic [NP-1:0] dat_wr;
   logic [NP-1:0] own_wr;
   logic [NP-1:0] mask_wr;
   logic [NP-1:0] rdiv_wr;
   logic [NP-1:0] tdiv_wr;
   logic [NP-1:0] tx_start;
   logic [NP-1:0] tx_busy;
   logic [NP-1:0] tx_done;
   logic [NP-1:0] data_done;
   logic [NP-1:0] stop_done;
   logic [NP-1:0] sm2_eff;
   logic [NP-1:0] addr_hit;
   logic [NP-1:0] rx_accept;
   logic [NP-1:0] fe_set;
   rx_frame_t frame [NP];
   port_cfg_t cfg [NP];

   // Register write decode; each port owns a 16-byte window
   always_comb
   begin
      pwr_wr = i_wr_en && (i_addr == `PWR_CTRL_ADDR);
      irq_stat_wr = i_wr_en && (i_addr == `IRQ_STAT_ADDR);
      irq_mask_wr = i_wr_en && (i_addr == `IRQ_MASK_ADDR);
      for (int p = 0; p < NP; p++)
      begin
         logic sel;
         sel = i_wr_en && (i_addr[7:4] == ((p == 0) ? `PORT0_BASE : `PORT1_BASE));
         scr_wr[p] = sel && (i_addr[3:0] == `OFS_SCR);
         dat_wr[p] = sel && (i_addr[3:0] == `OFS_DATA);
         own_wr[p] = sel && (i_addr[3:0] == `OFS_OWN_ADDR);
         mask_wr[p] = sel && (i_addr[3:0] == `OFS_ADDR_MASK);
         rdiv_wr[p] = sel && (i_addr[3:0] == `OFS_RX_DIV);
         tdiv_wr[p] = sel && (i_addr[3:0] == `OFS_TX_DIV);
         // A write while the shifter is busy is dropped, not queued
         tx_start[p] = dat_wr[p] && !tx_busy[p];
      end
   end

   // Two identical engines, one per port
   for (genvar g = 0; g < NP; g++)
   begin : g_port
      assign cfg[g] = '{mode: scr_q[g][`SCR_MODE_HI:`SCR_MODE_LO], rx_en: scr_q[g][`SCR_REN],
                        rx_div: rx_div_q[g], tx_div: tx_div_q[g]};
      uart_port_engine u_engine (
         .i_clk_sys(i_clk_sys),
         .i_rst(i_rst),
         .i_rx_pin(i_rx_pin[g]),
         .o_tx_pin(o_tx_pin[g]),
         .i_cfg(cfg[g]),
         .i_tx_start(tx_start[g]),
         .i_tx_data({scr_q[g][`SCR_TB8], i_wr_data}),
         .o_tx_busy(tx_busy[g]),
         .o_tx_done(tx_done[g]),
         .o_data_done(data_done[g]),
         .o_stop_done(stop_done[g]),
         .o_frame(frame[g])
      );
   end

   // Receive decision: framing check, completion point and address filter
   always_comb
   begin
      for (int p = 0; p < NP; p++)
      begin
         logic [1:0] mode;
         logic [7:0] bcast;
         logic given_hit;
         logic bcast_hit;
         logic point;
         mode = scr_q[p][`SCR_MODE_HI:`SCR_MODE_LO];
         bcast = own_addr_q[p] | mask_q[p];
         // Mask zeros are don't-care bits of the given address
         given_hit = ((frame[p].data ^ own_addr_q[p]) & mask_q[p]) == 8'h00;
         // Broadcast zeros are don't-care; ones must be received as ones
         bcast_hit = (frame[p].data & bcast) == bcast;
         addr_hit[p] = given_hit || bcast_hit;
         // Mode 0 ignores the multiprocessor enable
         sm2_eff[p] = scr_q[p][`SCR_MPE] && (mode != `MODE_SHIFT);
         // Checks on, or mode 1 filtering, move completion to the stop bit
         point = (fce_q[p] || (sm2_eff[p] && mode == `MODE_UART8)) ? stop_done[p]
                                                                 : data_done[p];
         if (!sm2_eff[p])
            rx_accept[p] = point;
         else if (mode == `MODE_UART8)
            rx_accept[p] = point && frame[p].stop_ok && addr_hit[p];
         else
            rx_accept[p] = point && frame[p].ninth && addr_hit[p];
         fe_set[p] = stop_done[p] && fce_q[p] && (mode != `MODE_SHIFT)
                     && !frame[p].stop_ok;
      end
   end

   // Serial control: hardware set wins over a software clear in one cycle
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int p = 0; p < NP; p++)
            scr_q[p] <= `SCR_RST;
      end
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (scr_wr[p])
            begin
               // Top bit is the mode bit only while the framing check is off
               scr_q[p][`SCR_MODE_LO:0] <= i_wr_data[`SCR_MODE_LO:0];
               if (!fce_q[p])
                  scr_q[p][`SCR_MODE_HI] <= i_wr_data[`SCR_MODE_HI];
            end
            if (rx_accept[p] && scr_q[p][`SCR_MODE_HI:`SCR_MODE_LO] != `MODE_SHIFT)
               scr_q[p][`SCR_RB8] <= frame[p].ninth;
            if (rx_accept[p])
               scr_q[p][`SCR_RXC] <= 1'h1;
            if (tx_done[p])
               scr_q[p][`SCR_TXD] <= 1'h1;
         end
      end
   end

   // Frame error: sticky, only a software write or reset clears it
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         fe_q <= '0;
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (fe_set[p])
               fe_q[p] <= 1'h1;
            else if (scr_wr[p] && fce_q[p])
               fe_q[p] <= i_wr_data[`SCR_MODE_HI];
         end
      end
   end

   // Address, mask, buffer and divider registers per port
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int p = 0; p < NP; p++)
         begin
            own_addr_q[p] <= `ADDR_RST;
            mask_q[p] <= `MASK_RST;
            rx_buf_q[p] <= 8'h00;
            rx_div_q[p] <= `BAUD_DIV_RST;
            tx_div_q[p] <= `BAUD_DIV_RST;
         end
      end
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (own_wr[p])
               own_addr_q[p] <= i_wr_data;
            if (mask_wr[p])
               mask_q[p] <= i_wr_data;
            if (rdiv_wr[p])
               rx_div_q[p] <= i_wr_data;
            if (tdiv_wr[p])
               tx_div_q[p] <= i_wr_data;
            // Rejected address frames never reach the buffer
            if (rx_accept[p])
               rx_buf_q[p] <= frame[p].data;
         end
      end
   end

   // Framing check enables, one per port
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         fce_q <= `FCE_RST;
      else if (pwr_wr)
         fce_q <= i_wr_data[NP-1:0];
   end

   // Interrupt status, cleared by writing ones; new events win
   always_comb
   begin
      for (int p = 0; p < NP; p++)
      begin
         irq_set[`IRQ_STRIDE * p + `IRQ_RXC] = rx_accept[p];
         irq_set[`IRQ_STRIDE * p + `IRQ_TXD] = tx_done[p];
         irq_set[`IRQ_STRIDE * p + `IRQ_FE] = fe_set[p];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_stat_q <= `IRQ_RST;
         irq_mask_q <= `IRQ_RST;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~(irq_stat_wr ? i_wr_data[5:0] : 6'h00)) | irq_set;
         if (irq_mask_wr)
            irq_mask_q <= i_wr_data[5:0];
      end
   end

   // Level output straight from flops, so no extra latency on the line
   assign o_irq = |(irq_stat_q & irq_mask_q);

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rd_mux = 8'h00;
      case (i_addr)
         `PWR_CTRL_ADDR: rd_mux = {6'h00, fce_q};
         `IRQ_STAT_ADDR: rd_mux = {2'h0, irq_stat_q};
         `IRQ_MASK_ADDR: rd_mux = {2'h0, irq_mask_q};
         default:
            for (int p = 0; p < NP; p++)
            begin
               if (i_addr[7:4] == ((p == 0) ? `PORT0_BASE : `PORT1_BASE))
               begin
                  case (i_addr[3:0])
                     `OFS_SCR: rd_mux = {fce_q[p] ? fe_q[p] : scr_q[p][7], scr_q[p][6:0]};
                     `OFS_DATA: rd_mux = rx_buf_q[p];
                     `OFS_OWN_ADDR: rd_mux = own_addr_q[p];
                     `OFS_ADDR_MASK: rd_mux = mask_q[p];
                     `OFS_RX_DIV: rd_mux = rx_div_q[p];
                     `OFS_TX_DIV: rd_mux = tx_div_q[p];
                     default: rd_mux = 8'h00;
                  endcase
               end
            end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         rd_data_q <= 8'h00;
      else
         rd_data_q <= i_rd_en ? rd_mux : 8'h00;
   end

   assign o_rd_data = rd_data_q;

   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   chk_fe_sticky: assert property (fe_q[1] && !scr_wr[1] |=> fe_q[1])
      else $error("frame error flag cleared without a write");
   chk_fe_sets: assert property (fe_set[1] |=> fe_q[1] && irq_stat_q[`IRQ_STRIDE + `IRQ_FE])
      else $error("bad stop bit did not set frame error");
   chk_fe_off: assert property (!fce_q[0] && !fe_q[0] && !scr_wr[0] |=> !fe_q[0])
      else $error("frame error set with framing check off");
   chk_ri_at_stop: assert property (fce_q[1] && data_done[1] && !stop_done[1]
      && !scr_q[1][`SCR_RXC] && !scr_wr[1] |=> !scr_q[1][`SCR_RXC])
      else $error("receive complete rose before the stop bit");
   chk_miss_dropped: assert property (sm2_eff[0] && scr_q[0][`SCR_MODE_HI]
      && data_done[0] && !addr_hit[0] |=> $stable(rx_buf_q[0]))
      else $error("mismatched address frame reached the buffer");
   chk_mode1_stop: assert property (sm2_eff[1] && !scr_q[1][`SCR_MODE_HI] && stop_done[1]
      && !frame[1].stop_ok && !scr_q[1][`SCR_RXC] && !scr_wr[1]
      |=> !scr_q[1][`SCR_RXC])
      else $error("mode 1 frame with bad stop completed");
   chk_mode0_mpe: assert property (scr_q[1][`SCR_MODE_HI:`SCR_MODE_LO] == `MODE_SHIFT
      && data_done[1] |=> scr_q[1][`SCR_RXC] ##0 rx_buf_q[1] == $past(frame[1].data))
      else $error("mode 0 frame filtered");
   chk_reset_any: assert property (own_addr_q[1] == 8'h00 && mask_q[1] == 8'h00
      |-> addr_hit[1])
      else $error("reset address values did not match all");
   chk_exact_miss: assert property (mask_q[1] == 8'hff && frame[1].data != own_addr_q[1]
      && (frame[1].data & own_addr_q[1]) != own_addr_q[1] |-> !addr_hit[1])
      else $error("exact mask matched a foreign address");
   chk_bcast_ff: assert property (frame[0].data == 8'hff |-> addr_hit[0])
      else $error("all-ones address not accepted");
   chk_port1_fe: assert property (fe_set[1] |=> fe_q[1] ##1 (fe_q[1] || $past(scr_wr[1])))
      else $error("port 1 frame error not held");
   chk_tx_runs: assert property (tx_start[0] |=> tx_busy[0] && !o_tx_pin[0])
      else $error("transmit did not start");

   cov_frame_error: cover property (fe_set[1] ##1 fe_q[1]);
   cov_addr_accept: cover property (sm2_eff[0] && rx_accept[0]);
   cov_full_duplex: cover property (tx_busy[0] && rx_accept[0]);

endmodule

`default_nettype wire

// >>> rtl/uart_port_engine.sv
// Purpose: One serial port line engine: receive and transmit shifters.
// Assumes: Line is idle high; 16x oversampling from a per-direction divider.
// Notes:   Mode 0 receive is a plain start plus eight bits frame; transmit still adds a stop bit.
`default_nettype none
`include "uart_addr_regs.svh"

module uart_port_engine
   import uart_addr_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Serial line
   input wire logic i_rx_pin,
   output logic o_tx_pin,
   // Configuration
   input wire port_cfg_t i_cfg,
   // Transmit request
   input wire logic i_tx_start,
   input wire logic [8:0] i_tx_data,
   output logic o_tx_busy,
   output logic o_tx_done,
   // Receive results
   output logic o_data_done,
   output logic o_stop_done,
   output rx_frame_t o_frame
);

   logic rx_meta_q;
   logic rx_sync_q;
   logic [7:0] rx_div_q;
   logic rx_tick;
   rx_state_t rx_state_q;
   logic [3:0] rx_ovs_q;
   logic [3:0] rx_bit_q;
   logic [8:0] rx_sh_q;
   logic [3:0] rx_last;
   logic [7:0] tx_div_q;
   logic tx_tick;
   tx_state_t tx_state_q;
   logic [3:0] tx_ovs_q;
   logic [3:0] tx_bit_q;
   logic [10:0] tx_sh_q;
   logic tx_pin_q;
   logic [3:0] tx_last;

   // Line synchroniser, the first stage feeds only the second
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_meta_q <= 1'h1;
         rx_sync_q <= 1'h1;
      end
      else
      begin
         rx_meta_q <= i_rx_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   // Receive and transmit run from their own dividers, so rates may differ
   assign rx_tick = (rx_div_q == i_cfg.rx_div);
   assign tx_tick = (tx_div_q == i_cfg.tx_div);
   assign rx_last = i_cfg.mode[1] ? `RX_LAST_NINE : `RX_LAST_EIGHT;
   assign tx_last = i_cfg.mode[1] ? `TX_LAST_NINE : `TX_LAST_EIGHT;

   // Receive divider, held at zero while idle to align with the start edge
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         rx_div_q <= 8'h00;
      else if (rx_state_q == RX_IDLE || rx_tick)
         rx_div_q <= 8'h00;
      else
         rx_div_q <= rx_div_q + 8'h01;
   end

   // Receive sequencer; data and stop points are separate pulses, raised in the same cycle in mode 0
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_state_q <= RX_IDLE;
         rx_ovs_q <= 4'h0;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 9'h000;
         o_data_done <= 1'h0;
         o_stop_done <= 1'h0;
         o_frame <= '0;
      end
      else
      begin
         o_data_done <= 1'h0;
         o_stop_done <= 1'h0;
         case (rx_state_q)
            RX_IDLE:
               if (i_cfg.rx_en && !rx_sync_q)
               begin
                  rx_state_q <= RX_START;
                  rx_ovs_q <= 4'h0;
                  rx_bit_q <= 4'h0;
               end
            RX_START:
               if (rx_tick)
               begin
                  if (rx_ovs_q == `OVS_MID)
                  begin
                     // A glitch shorter than half a bit is a false start
                     rx_ovs_q <= 4'h0;
                     rx_state_q <= rx_sync_q ? RX_IDLE : RX_DATA;
                  end
                  else
                     rx_ovs_q <= rx_ovs_q + 4'h1;
               end
            RX_DATA:
               if (rx_tick)
               begin
                  rx_ovs_q <= rx_ovs_q + 4'h1;
                  if (rx_ovs_q == `OVS_LAST)
                  begin
                     rx_sh_q <= {rx_sync_q, rx_sh_q[8:1]};
                     rx_bit_q <= rx_bit_q + 4'h1;
                     if (rx_bit_q == rx_last)
                     begin
                        o_data_done <= 1'h1;
                        o_frame.data <= i_cfg.mode[1] ? rx_sh_q[8:1] : {rx_sync_q, rx_sh_q[8:2]};
                        o_frame.ninth <= i_cfg.mode[1] ? rx_sync_q : 1'h1;
                        o_frame.stop_ok <= 1'h1;
                        if (i_cfg.mode == `MODE_SHIFT)
                        begin
                           o_stop_done <= 1'h1;
                           rx_state_q <= RX_IDLE;
                        end
                        else
                           rx_state_q <= RX_STOP;
                     end
                  end
               end
            RX_STOP:
               if (rx_tick)
               begin
                  rx_ovs_q <= rx_ovs_q + 4'h1;
                  if (rx_ovs_q == `OVS_LAST)
                  begin
                     // Stop sampled mid-bit; in mode 1 it is also the ninth bit
                     o_stop_done <= 1'h1;
                     o_frame.stop_ok <= rx_sync_q;
                     if (!i_cfg.mode[1])
                        o_frame.ninth <= rx_sync_q;
                     rx_state_q <= RX_IDLE;
                  end
               end
            default:
               rx_state_q <= RX_IDLE;
         endcase
      end
   end

   // Transmit divider
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         tx_div_q <= 8'h00;
      else if (tx_state_q == TX_IDLE || tx_tick)
         tx_div_q <= 8'h00;
      else
         tx_div_q <= tx_div_q + 8'h01;
   end

   // Transmit shifter, independent of the receiver
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         tx_state_q <= TX_IDLE;
         tx_ovs_q <= 4'h0;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 11'h7ff;
         tx_pin_q <= 1'h1;
         o_tx_done <= 1'h0;
      end
      else
      begin
         o_tx_done <= 1'h0;
         case (tx_state_q)
            TX_IDLE:
               if (i_tx_start)
               begin
                  tx_sh_q <= {1'h1, i_cfg.mode[1] ? i_tx_data[8] : 1'h1, i_tx_data[7:0], 1'h0};
                  tx_pin_q <= 1'h0;
                  tx_ovs_q <= 4'h0;
                  tx_bit_q <= 4'h0;
                  tx_state_q <= TX_SHIFT;
               end
            TX_SHIFT:
               if (tx_tick)
               begin
                  tx_ovs_q <= tx_ovs_q + 4'h1;
                  if (tx_ovs_q == `OVS_LAST)
                  begin
                     tx_sh_q <= {1'h1, tx_sh_q[10:1]};
                     tx_pin_q <= tx_sh_q[1];
                     tx_bit_q <= tx_bit_q + 4'h1;
                     if (tx_bit_q == tx_last)
                     begin
                        tx_pin_q <= 1'h1;
                        o_tx_done <= 1'h1;
                        tx_state_q <= TX_IDLE;
                     end
                  end
               end
            default:
               tx_state_q <= TX_IDLE;
         endcase
      end
   end

   assign o_tx_busy = (tx_state_q != TX_IDLE);
   assign o_tx_pin = tx_pin_q;

endmodule

`default_nettype wire

// >>> shared/uart_addr_pkg.sv
// Purpose: Types shared by the serial port engine and the register top.
// Assumes: Nothing beyond the register header.
// Notes:   Mode numbers live in the header; only types here.
`default_nettype none

package uart_addr_pkg;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

   // Static configuration handed to one port engine
   typedef struct packed {
      logic [1:0] mode;
      logic rx_en;
      logic [7:0] rx_div;
      logic [7:0] tx_div;
   } port_cfg_t;

   // Result of one received frame
   typedef struct packed {
      logic [7:0] data;
      logic ninth;
      logic stop_ok;
   } rx_frame_t;

endpackage

`default_nettype wire

// >>> shared/uart_addr_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the dual serial port with framing check and address match.
// Assumes: Byte-wide register port, one byte per address.
// Notes:   Definitions only.
`ifndef UART_ADDR_REGS_SVH
`define UART_ADDR_REGS_SVH

// Port count
`define NUM_PORTS 2

// Global register addresses
`define PWR_CTRL_ADDR 8'h00
`define IRQ_STAT_ADDR 8'h01
`define IRQ_MASK_ADDR 8'h02

// Per port windows: upper address nibble picks the port
`define PORT0_BASE 4'h1
`define PORT1_BASE 4'h2
`define OFS_SCR 4'h0
`define OFS_DATA 4'h1
`define OFS_OWN_ADDR 4'h2
`define OFS_ADDR_MASK 4'h3
`define OFS_RX_DIV 4'h4
`define OFS_TX_DIV 4'h5

// Serial control register fields
`define SCR_MODE_HI 7
`define SCR_MODE_LO 6
`define SCR_MPE 5
`define SCR_REN 4
`define SCR_TB8 3
`define SCR_RB8 2
`define SCR_TXD 1
`define SCR_RXC 0

// Serial modes
`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1

// Interrupt status layout: three bits per port
`define IRQ_STRIDE 3
`define IRQ_RXC 0
`define IRQ_TXD 1
`define IRQ_FE 2

// Reset values
`define SCR_RST 8'h00
`define ADDR_RST 8'h00
`define MASK_RST 8'h00
`define IRQ_RST 6'h00
`define FCE_RST 2'h0
// 125 MHz / 16 / 68 is about 115200 baud
`define BAUD_DIV_RST 8'h43

// Oversampling and bit counts
`define OVS_MID 4'h7
`define OVS_LAST 4'hf
`define RX_LAST_EIGHT 4'h7
`define RX_LAST_NINE 4'h8
`define TX_LAST_EIGHT 4'h9
`define TX_LAST_NINE 4'ha

`endif

// >>> verification/serial_node.sv
// Purpose: Remote node that drives one receive line of the block.
// Assumes: Divider 00, so one bit lasts 16 clocks of 8 ns.
// Notes: Line idles high, as a pulled-up wire would.
`default_nettype none
module serial_node (
   // Line toward the block
   output var logic o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_line = 1'b1;
   // Start, data LSB first, optional ninth bit, then stop bit
   task automatic send(input logic [7:0] d, input logic n9, input logic use9,
                       input logic stop);
      logic [10:0] f;
      f = {stop, n9, d, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         if (i != 9 || use9)
         begin
            o_line = f[i];
            #128;
         end
      end
      o_line = 1'b1; // Back to idle so a bad stop bit is not stretched
      #200;
   endtask
endmodule
`default_nettype wire

// >>> verification/test_uart_frame_addr_top.sv
// Purpose: Self-checking bench for the dual serial port block.
// Assumes: Dividers set to 00 by reset value override through writes.
// Notes: Flags are read back through the interrupt status register.
`default_nettype none
module test_uart_frame_addr_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0, o_irq;
   logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data, v;
   wire [1:0] rx;
   logic [1:0] o_tx_pin;
   int num_errors = 0, checks = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   uart_frame_addr_top i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .o_rd_data(o_rd_data), .i_rx_pin(rx), .o_tx_pin(o_tx_pin), .o_irq(o_irq));
   serial_node i_node0 (.o_line(rx[0]));
   serial_node i_node1 (.o_line(rx[1]));
   task automatic end_sim();
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_clk_sys);
      i_wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_clk_sys);
      i_rd_en <= 1'b0;
      #1;
      chk(o_rd_data, exp);
   endtask
   // Address filter on port 0 in mode 2
   task automatic addr_match();
      wr(8'h14, 8'h00);
      wr(8'h12, 8'h56);
      wr(8'h13, 8'hfc);
      wr(8'h10, 8'hb0);
      i_node0.send(8'h57, 1'b1, 1'b1, 1'b1);
      rd(8'h01, 8'h01);
      wr(8'h01, 8'h01);
      i_node0.send(8'h58, 1'b1, 1'b1, 1'b1);
      rd(8'h01, 8'h00);
      rd(8'h11, 8'h57);
      i_node0.send(8'h56, 1'b0, 1'b1, 1'b1);
      rd(8'h01, 8'h00);
      i_node0.send(8'hff, 1'b1, 1'b1, 1'b1);
      rd(8'h11, 8'hff);
      wr(8'h02, 8'h01);
      chk({7'h00, o_irq}, 8'h01);
      wr(8'h01, 8'h01);
      chk({7'h00, o_irq}, 8'h00);
   endtask
   // Port 0 transmits while it receives a broadcast frame
   task automatic duplex();
      logic [10:0] f;
      f = {2'b10, 8'h3a, 1'b0};
      wr(8'h15, 8'h00);
      wr(8'h11, 8'h3a);
      fork
         i_node0.send(8'hfe, 1'b1, 1'b1, 1'b1);
         for (int i = 0; i < 11; i++)
         begin
            repeat (i == 0 ? 8 : 16) @(posedge i_clk_sys);
            #1 chk({7'h00, o_tx_pin[0]}, {7'h00, f[i]});
         end
      join
      rd(8'h01, 8'h03);
      rd(8'h11, 8'hfe);
      wr(8'h01, 8'h03);
   endtask
   // Port 1: mode 0 ignores filtering, mode 1 needs exact match and good stop
   task automatic mode0_filter();
      wr(8'h22, 8'h11);
      wr(8'h23, 8'hff);
      wr(8'h20, 8'h30);
      i_node1.send(8'h3c, 1'b0, 1'b0, 1'b1);
      rd(8'h21, 8'h3c);
      rd(8'h01, 8'h08);
      wr(8'h01, 8'h08);
      wr(8'h20, 8'h70);
      i_node1.send(8'h12, 1'b0, 1'b0, 1'b1);
      i_node1.send(8'h11, 1'b0, 1'b0, 1'b0);
      rd(8'h01, 8'h20);
      rd(8'h21, 8'h3c);
      i_node1.send(8'h11, 1'b0, 1'b0, 1'b1);
      rd(8'h21, 8'h11);
   endtask
   // Stop-bit check on port 1 in mode 1
   task automatic frame_err();
      wr(8'h24, 8'h00);
      wr(8'h00, 8'h02);
      wr(8'h20, 8'h50);
      i_node1.send(8'ha5, 1'b0, 1'b0, 1'b0);
      rd(8'h01, 8'h28);
      i_node1.send(8'h3c, 1'b0, 1'b0, 1'b1);
      rd(8'h01, 8'h28);
      rd(8'h20, 8'hd5);
      wr(8'h01, 8'h28);
      rd(8'h01, 8'h00);
      wr(8'h20, 8'h50);
      rd(8'h20, 8'h50);
   endtask
   initial
   begin
      #400000;
      num_errors++;
      end_sim();
   end
   initial
   begin
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd(8'h12, 8'h00);
      rd(8'h23, 8'h00);
      rd(8'h7f, 8'h00);
      addr_match();
      duplex();
      frame_err();
      mode0_filter();
      end_sim();
   end
endmodule
`default_nettype wire
